//--- bench/cid_core_chk.sv
// Checker that watches the decoder core ports for phase, access and field relations.
module cid_core_chk #(
  parameter int unsigned PC_W = 13
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [PC_W-1:0] prog_addr,
  input  wire logic [6:0]      file_addr,
  input  wire logic            file_rd,
  input  wire logic            file_wr,
  input  wire logic [2:0]      bit_index,
  input  wire logic [10:0]     literal_k,
  input  wire logic            ctrl_op_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Properties.
  // ==========================================================================
  // A read or a write strobe can recur only in the next four-period cycle.
  property p_rd_gap; file_rd |=> !file_rd [*3]; endproperty
  property p_wr_gap; file_wr |=> !file_wr [*3]; endproperty
  // The store must follow its own read two periods later, at the same file.
  property p_rmw; file_wr |-> $past(file_rd, 2) && file_addr == $past(file_addr, 2); endproperty
  // The counter only ever moves forward by one word, once per cycle.
  property p_pc_inc; $changed(prog_addr) |-> prog_addr == PC_W'($past(prog_addr) + 1'b1);
  endproperty
  property p_pc_hold; $changed(prog_addr) |=> !$changed(prog_addr) [*3]; endproperty
  // A read in the second period is followed by retirement at the end of the fourth.
  property p_rd_retire; file_rd |-> ##[2:3] $changed(prog_addr); endproperty
  // Words of the other classes act as idle here, so they never store.
  property p_wr_idle; file_wr |-> !ctrl_op_pending; endproperty
  // All operand fields are slices of the same instruction word.
  property p_fields; literal_k[6:0] == file_addr && literal_k[7] == bit_index[0]; endproperty
  a_rd_gap:    assert property (p_rd_gap) else $error("file read repeated too soon");
  a_wr_gap:    assert property (p_wr_gap) else $error("file write repeated too soon");
  a_rmw:       assert property (p_rmw) else $error("file write without prior read");
  a_pc_inc:    assert property (p_pc_inc) else $error("counter step not one");
  a_pc_hold:   assert property (p_pc_hold) else $error("counter moved mid cycle");
  a_rd_retire: assert property (p_rd_retire) else $error("cycle did not retire");
  a_wr_idle:   assert property (p_wr_idle) else $error("idle class word stored");
  a_fields:    assert property (p_fields) else $error("operand fields disagree");
  c_wr:   cover property (file_rd ##2 file_wr);
  c_pend: cover property (ctrl_op_pending);
  c_pc:   cover property ($changed(prog_addr));
endmodule

bind cid_core cid_core_chk #(.PC_W(PC_W)) i_chk (.pclk(pclk), .presetn(presetn),
  .prog_addr(prog_addr), .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr),
  .bit_index(bit_index), .literal_k(literal_k), .ctrl_op_pending(ctrl_op_pending));

//--- bench/cid_core_tb.sv
// Self-checking bench that steps byte operations through the core one cycle at a time.
module cid_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        file_rd, file_wr, pend, d, err;
  logic [7:0]  paddr, file_rdata, file_wdata, wv, fv, gv;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] prog_addr;
  logic [13:0] prog_data;
  logic [6:0]  file_addr, fa, ff, fx;
  logic [3:0]  op;
  logic [14:0] e;
  logic [31:0] lfsr = 32'h00013a73;
  logic [3:0]  ops [0:13] = '{4'h7, 4'h2, 4'ha, 4'h3, 4'h4, 4'h5, 4'h9, 4'hb, 4'hf, 4'hd,
                              4'hc, 4'h1, 4'h8, 4'h0};
  int          n_mismatch = 0;
  int          n_tests = 0;
  cid_core i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data),
    .file_addr(file_addr), .file_rd(file_rd), .file_rdata(file_rdata), .file_wr(file_wr),
    .file_wdata(file_wdata), .bit_index(), .literal_k(), .ctrl_op_pending(pend));
  cid_mem_model i_mem (.pclk(pclk), .prog_addr(prog_addr), .prog_data(prog_data),
    .file_addr(file_addr), .file_rd(file_rd), .file_rdata(file_rdata), .file_wr(file_wr),
    .file_wdata(file_wdata));
  // ==========================================================================
  // Helpers.
  // ==========================================================================
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Returns skip, updated-flag mask, flags {Z,DC,C} and result; carry in is always clear.
  function automatic logic [14:0] exp_op(logic [3:0] o, logic [7:0] w, logic [7:0] f);
    logic [8:0] s;
    logic [2:0] upd;
    logic       c, dc, sk;
    {sk, dc, c, upd, s} = {3'h0, 3'h4, 1'b0, f};
    case (o)
      4'h7: begin
        s = {1'b0, f} + {1'b0, w};
        c = s[8];
        dc = ({1'b0, f[3:0]} + {1'b0, w[3:0]}) > 5'h0f;
        upd = 3'h7;
      end
      4'h2: begin
        s = {1'b0, f - w};
        c = f >= w;
        dc = f[3:0] >= w[3:0];
        upd = 3'h7;
      end
      4'ha: s[7:0] = f + 8'h01;
      4'h3: s[7:0] = f - 8'h01;
      4'h4: s[7:0] = f | w;
      4'h5: s[7:0] = f & w;
      4'h9: s[7:0] = ~f;
      4'hb: begin
        s[7:0] = f - 8'h01;
        upd = 3'h0;
        sk = f == 8'h01;
      end
      4'hf: begin
        s[7:0] = f + 8'h01;
        upd = 3'h0;
        sk = f == 8'hff;
      end
      4'hd: {c, s[7:0]} = {f, 1'b0};
      4'hc: {s[7:0], c} = {1'b0, f};
      4'h1: s[7:0] = 8'h00;
      4'h0: {upd, s[7:0]} = {3'h0, w};
      default: s[7:0] = f;
    endcase
    if (o == 4'hd || o == 4'hc) upd = 3'h1;
    return {sk, upd, s[7:0] == 8'h00, dc, c, s[7:0]};
  endfunction
  // A bus cycle holds its request until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Runs one instruction cycle and polls until the step request clears itself.
  task automatic step();
    apb(1'b1, cid_pkg::REG_CTRL, 32'h00000002);
    do apb(1'b0, cid_pkg::REG_CTRL, 32'h00000000); while (rd[1] !== 1'b0);
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // About 2640 cycles are needed, so this limit only trips on a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end
  // ==========================================================================
  // Main sequence: copy to acc, operation, skip probe, idle-class word.
  // ==========================================================================
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h3c, 32'h00000000);
    chk("unmapped", 32'h00000000, rd);
    chk("slverr", 32'h00000001, {31'h0, err});
    for (int i = 0; i < 56; i++) begin
      lfsr = nxt(lfsr);
      op = ops[i % 14];
      d = lfsr[0] | (op == 4'h0);
      {gv, fv, wv, fa} = lfsr[31:1];
      ff = fa ^ 7'h2a;
      fx = (op == 4'h1 && !d) ? lfsr[30:24] : ff;
      // First pass forces the zero result that makes the skip ops skip.
      if (i < 14 && (op == 4'hb || op == 4'hf)) fv = (op == 4'hb) ? 8'h01 : 8'hff;
      presetn <= 1'b0;
      i_mem.regs[fa] = wv;
      i_mem.regs[ff] = fv;
      i_mem.regs[fa ^ 7'h15] = gv;
      i_mem.rom[0] = {6'h08, 1'b0, fa};
      i_mem.rom[1] = {2'b00, op, d, fx};
      i_mem.rom[2] = {6'h0a, 1'b1, fa ^ 7'h15};
      i_mem.rom[3] = {2'b11, lfsr[11:0]};
      i_mem.rom[4] = 14'h0000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      e = exp_op(op, wv, fv);
      repeat (3) step();
      apb(1'b0, cid_pkg::REG_ACC, 32'h00000000);
      chk("acc", {24'h0, d ? wv : e[7:0]}, rd);
      apb(1'b0, cid_pkg::REG_STATUS, 32'h00000000);
      chk("status", {29'h0, ({wv == 8'h00, 2'b00} & ~e[13:11]) | (e[10:8] & e[13:11])}, rd);
      chk("file", {24'h0, d ? e[7:0] : fv}, {24'h0, i_mem.regs[ff]});
      step();
      chk("skip", {24'h0, gv + {7'h0, !e[14]}}, {24'h0, i_mem.regs[fa ^ 7'h15]});
      apb(1'b0, cid_pkg::REG_PC, 32'h00000000);
      chk("pc", 32'h00000004, rd);
      $display("Test %0d opcode %h dest %b done", i, op, d);
    end
    give_verdict();
  end
endmodule

//--- bench/cid_mem_model.sv
// Behavioural program memory and file register array facing the core.
module cid_mem_model (
  input  wire logic        pclk,
  input  wire logic [12:0] prog_addr,
  output logic [13:0]      prog_data,
  input  wire logic [6:0]  file_addr,
  input  wire logic        file_rd,
  output logic [7:0]       file_rdata,
  input  wire logic        file_wr,
  input  wire logic [7:0]  file_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] rom [0:15];
  logic [7:0]  regs [0:127];
  // Only sixteen words decode; the bench never runs further.
  assign prog_data = rom[prog_addr[3:0]];
  // Outside the read strobe the lines show the inverse, so a late capture goes wrong.
  assign file_rdata = file_rd ? regs[file_addr] : ~regs[file_addr];
  // The store lands on the edge that closes the fourth period.
  always @(posedge pclk) begin
    if (file_wr) begin
      regs[file_addr] <= file_wdata;
    end
  end
endmodule

//--- hdl/cid_alu.sv
// Byte-operation arithmetic and logic unit with carry, half carry and zero outputs.
module cid_alu (
  input  wire logic [3:0] op,
  input  wire logic       dest_sel,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] fval,
  input  wire logic       carry_in,
  output logic [7:0]      result,
  output logic            carry_out,
  output logic            half_carry_out,
  output logic            zero_out
);

  // ==========================================================================
  // Combinational datapath.
  // ==========================================================================
  logic [8:0] sum9;
  logic [4:0] nib5;

  // Subtraction is an add of the two's complement, so carry means no borrow.
  always_comb begin
    sum9           = 9'h000;
    nib5           = 5'h00;
    result         = fval;
    carry_out      = carry_in;
    half_carry_out = 1'b0;
    case (op)
      cid_pkg::OP_ADD: begin // [RQ10]
        sum9           = {1'b0, fval} + {1'b0, acc};
        nib5           = {1'b0, fval[3:0]} + {1'b0, acc[3:0]};
        result         = sum9[7:0];
        carry_out      = sum9[8];
        half_carry_out = nib5[4];
      end
      cid_pkg::OP_SUB: begin // [RQ10]
        sum9           = {1'b0, fval} + {1'b0, ~acc} + 9'h001;
        nib5           = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        result         = sum9[7:0];
        carry_out      = sum9[8];
        half_carry_out = nib5[4];
      end
      cid_pkg::OP_INC, cid_pkg::OP_INC_SKIP:  result = fval + 8'h01; // [RQ10] [RQ12]
      cid_pkg::OP_DEC, cid_pkg::OP_DEC_SKIP:  result = fval - 8'h01; // [RQ10] [RQ12]
      cid_pkg::OP_OR:                         result = acc | fval;   // [RQ11]
      cid_pkg::OP_AND:                        result = acc & fval;   // [RQ11]
      cid_pkg::OP_XOR:                        result = acc ^ fval;
      cid_pkg::OP_COMP:                       result = ~fval;        // [RQ11]
      cid_pkg::OP_SWAP:                       result = {fval[3:0], fval[7:4]};
      cid_pkg::OP_ROT_LEFT: begin // [RQ13]
        result    = {fval[6:0], carry_in};
        carry_out = fval[7];
      end
      cid_pkg::OP_ROT_RIGHT: begin // [RQ13]
        result    = {carry_in, fval[7:1]};
        carry_out = fval[0];
      end
      cid_pkg::OP_CLEAR:                      result = 8'h00;        // [RQ14]
      cid_pkg::OP_COPY:                       result = fval;         // [RQ15]
      cid_pkg::OP_STORE_ACC:                  result = dest_sel ? acc : fval; // [RQ15]
      default:                                result = fval;
    endcase
  end

  assign zero_out = (result == 8'h00);

endmodule

//--- hdl/cid_core.sv
// Instruction decoder and byte-operation execution core with an APB control port.
//
// Function
// (RQ1) Every instruction is one 14-bit word split into an opcode part and operand parts.
// (RQ2) For byte operations, destination bit 0 sends the result to the accumulator, 1 to the file.
// (RQ3) The file address operand is seven bits, selecting registers 0x00 through 0x7f.
// (RQ4) Bit operations use a three-bit index selecting one bit of the addressed 8-bit file.
// (RQ5) Literal and control operations carry an 8-bit or 11-bit immediate constant.
// (RQ6) Each instruction cycle is sequenced as four consecutive clock periods.
// (RQ7) Instructions take one cycle, or two when a test is true or the counter changes.
// (RQ8) Every instruction naming a file reads it first, modifies, then stores the result.
// (RQ9) Don't-care instruction bits are ignored, whether 0 or 1.
// (RQ10) Byte opcodes start 00; add 0111 and subtract 0010 set C, DC, Z; inc 1010, dec 0011 set Z.
// (RQ11) OR 0100, AND 0101 and complement 1001 update only the zero flag.
// (RQ12) Decrement-skip 1011 and increment-skip 1111 store and skip on zero, flags untouched.
// (RQ13) Rotate left 1101 and right 1100 pass through carry and update only carry.
// (RQ14) Opcode 0001 clears the file when the next bit is set, else the accumulator; Z is set.
// (RQ15) Opcode 1000 copies a file with Z update; 0000 with next bit set stores acc, no flags.
// (RQ16) The program counter advances one word after each instruction that neither branches nor skips.
//
// The address map and the APB interface to the registers are this design's own decisions.
module cid_core #(
  parameter int unsigned PC_W = cid_pkg::PC_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Program memory fetch port.
  output logic [PC_W-1:0]        prog_addr,
  input  wire logic [13:0]       prog_data,
  // File register port.
  output logic [6:0]             file_addr,
  output logic                   file_rd,
  input  wire logic [7:0]        file_rdata,
  output logic                   file_wr,
  output logic [7:0]             file_wdata,
  // Decoded operand fields of the current instruction.
  output logic [2:0]             bit_index,
  output logic [10:0]            literal_k,
  output logic                   ctrl_op_pending
);

  // ==========================================================================
  // State and instruction fields.
  // ==========================================================================
  cid_pkg::cid_phase_t phase;
  logic                cycle_end;
  logic                run_r;
  logic                step_r;
  logic [13:0]         insn_r;
  logic [7:0]          acc_r;
  logic [2:0]          status_r;
  logic [PC_W-1:0]     pc_r;
  logic                flush_r;
  logic [7:0]          fval_r;
  logic [31:0]         cycles_r;

  logic [1:0] op_class;
  logic [3:0] opcode;
  logic       dest_sel;
  logic [6:0] faddr;
  logic       is_byte;

  // Split the word into class, opcode and operand fields.
  assign op_class = insn_r[cid_pkg::CLASS_HI:cid_pkg::CLASS_LO]; // [RQ1]
  assign opcode   = insn_r[cid_pkg::OP_HI:cid_pkg::OP_LO]; // [RQ1] [RQ10]
  assign dest_sel = insn_r[cid_pkg::DEST_BIT]; // [RQ2]
  assign faddr    = insn_r[cid_pkg::FADDR_W-1:0]; // [RQ3]
  assign is_byte  = (op_class == cid_pkg::CLASS_BYTE) && !flush_r; // [RQ10]

  // Operand fields for the bit and literal units that sit outside this core.
  assign bit_index = insn_r[cid_pkg::BIT_IDX_LO+cid_pkg::BIT_IDX_W-1:cid_pkg::BIT_IDX_LO]; // [RQ4]
  assign literal_k = (op_class == cid_pkg::CLASS_CTRL) ?
                     insn_r[cid_pkg::LIT11_W-1:0] :
                     {3'h0, insn_r[cid_pkg::LIT8_W-1:0]}; // [RQ5]
  assign ctrl_op_pending = !flush_r && (op_class != cid_pkg::CLASS_BYTE);

  // ==========================================================================
  // Decode of byte operations.
  // ==========================================================================
  logic no_file;
  logic is_idle;
  logic writes_file;
  logic writes_acc;
  logic upd_z;
  logic upd_c;
  logic upd_dc;
  logic is_skip_op;

  // Bit 7 selects between the file and accumulator forms of 0000 and 0001; when
  // the accumulator form is chosen the low seven bits are don't-care.
  always_comb begin
    no_file     = 1'b0;
    is_idle     = 1'b0;
    writes_file = 1'b0;
    writes_acc  = 1'b0;
    upd_z       = 1'b0;
    upd_c       = 1'b0;
    upd_dc      = 1'b0;
    is_skip_op  = 1'b0;
    if (is_byte) begin
      case (opcode)
        cid_pkg::OP_STORE_ACC: begin
          is_idle     = !dest_sel; // [RQ9]
          no_file     = !dest_sel;
          writes_file = dest_sel; // [RQ15]
        end
        cid_pkg::OP_CLEAR: begin
          no_file     = !dest_sel; // [RQ9]
          writes_file = dest_sel; // [RQ14]
          writes_acc  = !dest_sel; // [RQ14]
          upd_z       = 1'b1;
        end
        cid_pkg::OP_ADD, cid_pkg::OP_SUB: begin
          writes_file = dest_sel; // [RQ2]
          writes_acc  = !dest_sel; // [RQ2]
          upd_z       = 1'b1;
          upd_c       = 1'b1; // [RQ10]
          upd_dc      = 1'b1; // [RQ10]
        end
        cid_pkg::OP_ROT_LEFT, cid_pkg::OP_ROT_RIGHT: begin
          writes_file = dest_sel;
          writes_acc  = !dest_sel;
          upd_c       = 1'b1; // [RQ13]
        end
        cid_pkg::OP_DEC_SKIP, cid_pkg::OP_INC_SKIP: begin
          writes_file = dest_sel;
          writes_acc  = !dest_sel;
          is_skip_op  = 1'b1; // [RQ12]
        end
        cid_pkg::OP_SWAP: begin
          writes_file = dest_sel;
          writes_acc  = !dest_sel;
        end
        default: begin
          writes_file = dest_sel; // [RQ2]
          writes_acc  = !dest_sel; // [RQ2]
          upd_z       = 1'b1; // [RQ10] [RQ11] [RQ15]
        end
      endcase
    end
  end

  // ==========================================================================
  // Arithmetic unit and phase sequencer.
  // ==========================================================================
  logic [7:0] alu_result;
  logic       alu_c;
  logic       alu_dc;
  logic       alu_z;

  cid_alu u_alu (
    .op             (opcode),
    .dest_sel       (dest_sel),
    .acc            (acc_r),
    .fval           (no_file ? 8'h00 : fval_r),
    .carry_in       (status_r[cid_pkg::FLAG_C]),
    .result         (alu_result),
    .carry_out      (alu_c),
    .half_carry_out (alu_dc),
    .zero_out       (alu_z)
  );

  logic run_eff;

  assign run_eff = run_r || step_r;

  cid_phase_gen u_phase (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .run       (run_eff),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  // ==========================================================================
  // File register access.
  // ==========================================================================
  logic take_skip;

  // The file is always read in Q2, even for a pure store, because the bus
  // below may have read side effects that software relies on.
  assign file_addr  = faddr;
  assign file_rd    = clk_en && run_eff && is_byte && !no_file
                      && (phase == cid_pkg::CID_PH_Q2); // [RQ8]
  assign file_wr    = cycle_end && is_byte && writes_file; // [RQ8] [RQ2]
  assign file_wdata = alu_result;
  assign take_skip  = is_skip_op && alu_z; // [RQ12]

  // Latch the read value so the modify step works from a stable operand.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fval_r <= 8'h00;
    end else if (file_rd) begin
      fval_r <= file_rdata; // [RQ8]
    end
  end

  // ==========================================================================
  // Accumulator and status flags.
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= cid_pkg::ACC_RESET;
    end else if (cycle_end && writes_acc) begin
      acc_r <= alu_result; // [RQ2] [RQ15]
    end
  end

  // Flags change only where the decode allows; skips and stores touch none.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= cid_pkg::STATUS_RESET;
    end else if (cycle_end && !is_idle) begin
      if (upd_z)  status_r[cid_pkg::FLAG_Z]  <= alu_z; // [RQ10] [RQ14]
      if (upd_c)  status_r[cid_pkg::FLAG_C]  <= alu_c; // [RQ13]
      if (upd_dc) status_r[cid_pkg::FLAG_DC] <= alu_dc; // [RQ10]
    end
  end

  // ==========================================================================
  // Fetch, program counter and two-cycle stretching.
  // ==========================================================================
  // A taken skip turns the already fetched word into an idle second cycle, so
  // the counter still advances by one each cycle and the skipped word is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r    <= cid_pkg::PC_RESET;
      insn_r  <= 14'h0000;
      flush_r <= 1'b1;
    end else if (cycle_end) begin
      insn_r  <= prog_data; // [RQ1]
      pc_r    <= pc_r + {{(PC_W-1){1'b0}}, 1'b1}; // [RQ16]
      flush_r <= take_skip; // [RQ7] [RQ12]
    end
  end

  assign prog_addr = pc_r;

  // Retired instruction cycles, for software profiling.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycles_r <= 32'h0000_0000;
    end else if (cycle_end) begin
      cycles_r <= cycles_r + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // APB slave.
  // ==========================================================================
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;

  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !pwrite;
  assign addr_ok = (paddr == cid_pkg::REG_CTRL)   || (paddr == cid_pkg::REG_ACC)  ||
                   (paddr == cid_pkg::REG_STATUS) || (paddr == cid_pkg::REG_PC)   ||
                   (paddr == cid_pkg::REG_INSN)   || (paddr == cid_pkg::REG_CYCLES);
  assign pslverr = psel && penable && !addr_ok;

  // The step bit runs exactly one instruction cycle, then clears itself; a
  // write in the same edge that ends the step wins so no request is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r  <= 1'b0;
      step_r <= 1'b0;
    end else if (clk_en) begin
      if (apb_wr && paddr == cid_pkg::REG_CTRL) begin
        run_r  <= pwdata[cid_pkg::CTRL_RUN];
        step_r <= pwdata[cid_pkg::CTRL_STEP];
      end else if (cycle_end) begin
        step_r <= 1'b0;
      end
    end
  end

  // Read data is registered during setup so it is stable in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && apb_rd && !penable) begin
      case (paddr)
        cid_pkg::REG_CTRL:   prdata <= {30'h0, step_r, run_r};
        cid_pkg::REG_ACC:    prdata <= {24'h0, acc_r};
        cid_pkg::REG_STATUS: prdata <= {29'h0, status_r};
        cid_pkg::REG_PC:     prdata <= {{(32-PC_W){1'b0}}, pc_r};
        cid_pkg::REG_INSN:   prdata <= {17'h0, flush_r, insn_r};
        cid_pkg::REG_CYCLES: prdata <= cycles_r;
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

//--- hdl/cid_phase_gen.sv
// Quarter-phase sequencer that splits each instruction cycle into four clock periods.
module cid_phase_gen (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              run,
  output cid_pkg::cid_phase_t    phase,
  output logic                   cycle_end
);

  // ==========================================================================
  // Phase counter.
  // ==========================================================================
  cid_pkg::cid_phase_t phase_r;

  // Phases advance only while running, so a halted core stays parked at whichever phase it stopped in.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= cid_pkg::CID_PH_Q1;
    end else if (clk_en && run) begin
      case (phase_r) // [RQ6]
        cid_pkg::CID_PH_Q1: phase_r <= cid_pkg::CID_PH_Q2;
        cid_pkg::CID_PH_Q2: phase_r <= cid_pkg::CID_PH_Q3;
        cid_pkg::CID_PH_Q3: phase_r <= cid_pkg::CID_PH_Q4;
        cid_pkg::CID_PH_Q4: phase_r <= cid_pkg::CID_PH_Q1;
        default:            phase_r <= cid_pkg::CID_PH_Q1;
      endcase
    end
  end

  // The last quarter marks the edge at which the instruction retires.
  assign phase     = phase_r;
  assign cycle_end = clk_en && run && (phase_r == cid_pkg::CID_PH_Q4); // [RQ6]

endmodule

//--- hdl/cid_pkg.sv
// Package with instruction field layout, opcodes, timing and register map constants.
package cid_pkg;

  // ==========================================================================
  // Instruction word layout.
  // ==========================================================================
  localparam int unsigned INSN_W      = 14;
  localparam int unsigned CLASS_HI    = 13;
  localparam int unsigned CLASS_LO    = 12;
  localparam int unsigned OP_HI       = 11;
  localparam int unsigned OP_LO       = 8;
  localparam int unsigned DEST_BIT    = 7;
  localparam int unsigned FADDR_W     = 7;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned BIT_IDX_W   = 3;
  localparam int unsigned BIT_IDX_LO  = 7;
  localparam int unsigned LIT8_W      = 8;
  localparam int unsigned LIT11_W     = 11;
  localparam int unsigned PC_W        = 13;
  localparam int unsigned QPHASES     = 4;

  localparam logic [1:0] CLASS_BYTE = 2'h0;
  localparam logic [1:0] CLASS_BIT  = 2'h1;
  localparam logic [1:0] CLASS_CTRL = 2'h2;
  localparam logic [1:0] CLASS_LIT  = 2'h3;

  // Byte-oriented opcodes.
  localparam logic [3:0] OP_STORE_ACC   = 4'h0;
  localparam logic [3:0] OP_CLEAR       = 4'h1;
  localparam logic [3:0] OP_SUB         = 4'h2;
  localparam logic [3:0] OP_DEC         = 4'h3;
  localparam logic [3:0] OP_OR          = 4'h4;
  localparam logic [3:0] OP_AND         = 4'h5;
  localparam logic [3:0] OP_XOR         = 4'h6;
  localparam logic [3:0] OP_ADD         = 4'h7;
  localparam logic [3:0] OP_COPY        = 4'h8;
  localparam logic [3:0] OP_COMP        = 4'h9;
  localparam logic [3:0] OP_INC         = 4'ha;
  localparam logic [3:0] OP_DEC_SKIP    = 4'hb;
  localparam logic [3:0] OP_ROT_RIGHT   = 4'hc;
  localparam logic [3:0] OP_ROT_LEFT    = 4'hd;
  localparam logic [3:0] OP_SWAP        = 4'he;
  localparam logic [3:0] OP_INC_SKIP    = 4'hf;

  // Status flag positions in the status register.
  localparam int unsigned FLAG_C  = 0;
  localparam int unsigned FLAG_DC = 1;
  localparam int unsigned FLAG_Z  = 2;

  // ==========================================================================
  // APB register map, byte addresses.
  // ==========================================================================
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ACC    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0c;
  localparam logic [7:0] REG_INSN   = 8'h10;
  localparam logic [7:0] REG_CYCLES = 8'h14;

  localparam int unsigned CTRL_RUN  = 0;
  localparam int unsigned CTRL_STEP = 1;

  localparam logic [7:0]      ACC_RESET    = 8'h00;
  localparam logic [2:0]      STATUS_RESET = 3'h0;
  localparam logic [PC_W-1:0] PC_RESET     = 13'h0000;

  typedef enum logic [1:0] {
    CID_PH_Q1,
    CID_PH_Q2,
    CID_PH_Q3,
    CID_PH_Q4
  } cid_phase_t;

endpackage
